//--- include/frs_pkg.sv
// package: register map, field layout and types of the floppy rate/status register bank
package frs_pkg;

    // ========================================================
    // register map (byte addresses on the wishbone slave)
    // ========================================================
    localparam logic [11:0] ADDR_INPUT_CFG  = 12'h3F7;  // read: input status view, write: rate config
    localparam logic [11:0] ADDR_STATUS0    = 12'h3F8;  // result status byte zero, read-only
    localparam logic [11:0] ADDR_ST0_SRC    = 12'h3FC;  // status byte zero sources, read/write
    localparam logic [11:0] ADDR_OUT_CTRL   = 12'h3FD;  // output control: dma gate, soft reset
    localparam logic [11:0] ADDR_RESULT     = 12'h3FE;  // result data port, read-only
    localparam logic [11:0] ADDR_MODE       = 12'h3FF;  // mode and density state, read-only

    // ========================================================
    // field positions and constants
    // ========================================================
    localparam int          RATE_LO_BIT    = 0;
    localparam int          NO_WRITE_PRECOMP_BIT     = 2;
    localparam int          DMA_GATE_BIT   = 3;
    localparam int          SOFT_RST_BIT   = 2;
    localparam int          DISK_CHANGED_BIT     = 7;
    localparam int          HIDENS_BIT     = 0;
    localparam logic [1:0]  RATE_500K      = 2'h0;
    localparam logic [1:0]  RATE_300K      = 2'h1;
    localparam logic [1:0]  RATE_250K      = 2'h2;
    localparam logic [1:0]  RATE_1M        = 2'h3;
    localparam logic [1:0]  RATE_RESET     = RATE_250K;
    localparam logic [7:0]  ALL_ONES_MID   = 8'h78;     // bits 6:3 set
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
    localparam int          RECAL_STEPS    = 80;

    // compatibility views of the input register
    typedef enum logic [1:0] {
        FRS_MODE_A = 2'h0,
        FRS_MODE_B = 2'h1,
        FRS_MODE_C = 2'h2
    } frs_mode_t;

    // termination codes of status byte zero
    typedef enum logic [1:0] {
        FRS_TERM_NORMAL  = 2'h0,
        FRS_TERM_ABNORM  = 2'h1,
        FRS_TERM_INVALID = 2'h2,
        FRS_TERM_POLL    = 2'h3
    } frs_term_t;

    // status byte zero layout
    typedef struct packed {
        frs_term_t  terminationCode;
        logic       seekDone;
        logic       equipmentFault;
        logic       unused3;
        logic       headNumber;
        logic [1:0] driveNumber;
    } frs_st0_t;

    // classic wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } frs_wb_req_t;

    // classic wishbone answer
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } frs_wb_rsp_t;

endpackage : frs_pkg

//--- rtl/frs_floppy_rate_status_regs.sv
// file: register bank for input status views, rate config, density output and status byte zero
`timescale 1ns/1ps
module frs_floppy_rate_status_regs #(
    parameter int RECAL_LIMIT = frs_pkg::RECAL_STEPS
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire frs_pkg::frs_wb_req_t wbReq,
    output frs_pkg::frs_wb_rsp_t      wbRsp,
    output logic [7:0]               hostDataOe,
    input  wire frs_pkg::frs_mode_t   compatMode,
    input  wire logic                diskChanged,
    input  wire logic                densityPolarity,
    input  wire logic                trackZeroIn,
    input  wire logic                stepPulse,
    input  wire logic                recalStart,
    input  wire logic                relSeekOutward,
    input  wire logic                seekComplete,
    input  wire frs_pkg::frs_term_t   termCodeIn,
    input  wire logic                termValid,
    input  wire logic                resultPhase,
    input  wire logic [1:0]          curDrive,
    input  wire logic                curHead,
    output logic                     densityOut,
    output logic [1:0]               rateSelect,
    output logic                     softResetPulse
);

    // ========================================================
    // bus decode
    // ========================================================
    logic        access;
    logic        wrStrobe;
    logic        rdStrobe;
    logic        hitShared;
    logic        hitSt0;
    logic        hitSrc;
    logic        hitCtrl;
    logic        hitResult;
    logic        hitMode;
    logic        lane0;
    // every register here is one byte wide, so a write needs lane 0; a write
    // with lane 0 off is acked and dropped, like one to an unmapped address
    // ack only once per request; the cycle after ack is a gap
    assign access    = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
    assign lane0     = wbReq.sel[0];
    assign wrStrobe  = access & wbReq.we & lane0;
    assign rdStrobe  = access & ~wbReq.we;
    assign hitShared = (wbReq.adr == frs_pkg::ADDR_INPUT_CFG);
    assign hitSt0    = (wbReq.adr == frs_pkg::ADDR_STATUS0);
    assign hitSrc    = (wbReq.adr == frs_pkg::ADDR_ST0_SRC);
    assign hitCtrl   = (wbReq.adr == frs_pkg::ADDR_OUT_CTRL);
    assign hitResult = (wbReq.adr == frs_pkg::ADDR_RESULT);
    assign hitMode   = (wbReq.adr == frs_pkg::ADDR_MODE);

    // ========================================================
    // configuration state
    // ========================================================
    logic [1:0] rate_r;
    logic       noPrecomp_r;
    logic       dmaGate_r;
    logic       density_r;
    logic       softRst_r;
    logic       densityNxt;
    logic       densityBase;
    logic       cfgWrite;
    logic       ctrlWrite;
    logic [1:0] rateWrData;
    logic       noPrecompWrData;
    logic       dmaGateWrData;
    logic       softRstWrData;

    // shared address write
    // the shared address is read-only as a view; a write there always lands
    // in the rate config register, whatever the compatibility mode
    assign cfgWrite        = wrStrobe & hitShared;
    assign ctrlWrite       = wrStrobe & hitCtrl;
    assign rateWrData      = wbReq.dat[frs_pkg::RATE_LO_BIT +: 2];
    assign noPrecompWrData = wbReq.dat[frs_pkg::NO_WRITE_PRECOMP_BIT];
    assign dmaGateWrData   = wbReq.dat[frs_pkg::DMA_GATE_BIT];
    assign softRstWrData   = wbReq.dat[frs_pkg::SOFT_RST_BIT];

    // rate select: only the hardware reset reaches it, so a soft reset keeps
    // the rate that the driver software chose
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_r <= frs_pkg::RATE_RESET;
        end else if (cfgWrite) begin
            rate_r <= rateWrData;
        end
    end

    // store no-precomp
    // kept for read-back only; in modes A and B software writes it as zero,
    // so it only ever shows up in the mode C view
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            noPrecomp_r <= 1'b0;
        end else if (cfgWrite) begin
            noPrecomp_r <= noPrecompWrData;
        end
    end

    // dma gate copy of the output control register, read back in mode C
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaGate_r <= 1'b0;
        end else if (ctrlWrite) begin
            dmaGate_r <= dmaGateWrData;
        end
    end

    // self-clearing soft reset request, high for one cycle after the write;
    // nothing in this bank listens to it, it is meant for the command engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softRst_r <= 1'b0;
        end else begin
            softRst_r <= ctrlWrite & softRstWrData;
        end
    end

    assign densityBase = (rate_r == frs_pkg::RATE_300K) | (rate_r == frs_pkg::RATE_250K);
    assign densityNxt  = densityBase ^ densityPolarity;

    // density reset high
    // registered so the pin never glitches while the rate bits change; the
    // price is a one-cycle lag behind a rate write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            density_r <= 1'b1;
        end else begin
            density_r <= densityNxt;
        end
    end

    // ========================================================
    // status byte zero sources
    // ========================================================
    logic [7:0] stepCount_r;
    logic       recalActive_r;
    logic       seekDone_r;
    logic       eqFault_r;
    logic       recalFail;
    logic       recalEnd;
    logic       recalStep;
    logic       srcClear;

    assign srcClear  = wrStrobe & hitSrc;
    // recal step limit
    // the limit-th step with track zero still low is the miss; the count is
    // compared before it moves, hence the minus one
    assign recalFail = recalActive_r & stepPulse & ~trackZeroIn
                       & (stepCount_r == 8'(RECAL_LIMIT - 1));
    assign recalEnd  = recalActive_r & (trackZeroIn | recalFail);
    assign recalStep = recalActive_r & stepPulse & ~recalEnd;

    // step counter of the running recalibrate; 8 bits hold a limit up to 256
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stepCount_r <= 8'h00;
        end else if (recalStart) begin
            stepCount_r <= 8'h00;
        end else if (recalStep) begin
            stepCount_r <= stepCount_r + 8'h01;
        end
    end

    // recalibrate runs until track zero shows or the step limit is hit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            recalActive_r <= 1'b0;
        end else if (recalStart) begin
            recalActive_r <= 1'b1;
        end else if (recalEnd) begin
            recalActive_r <= 1'b0;
        end
    end

    // seek end flag
    // sticky until software clears it; a completion in the clear cycle wins,
    // so no event slips through a software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seekDone_r <= 1'b0;
        end else begin
            seekDone_r <= seekComplete | (seekDone_r & ~srcClear);
        end
    end

    // fault flag
    // same set-wins rule as the seek flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eqFault_r <= 1'b0;
        end else begin
            eqFault_r <= recalFail | relSeekOutward | (eqFault_r & ~srcClear);
        end
    end

    frs_pkg::frs_term_t term_r;
    // latched termination code of the last command; it stays until the
    // next command reports, so a late read still sees the last outcome
    // latched termination code of the last command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term_r <= frs_pkg::FRS_TERM_NORMAL;
        end else if (termValid) begin
            term_r <= termCodeIn;
        end
    end

    frs_pkg::frs_st0_t st0;
    assign st0.terminationCode = term_r;
    assign st0.seekDone        = seekDone_r;
    assign st0.equipmentFault  = eqFault_r;
    assign st0.unused3         = 1'b0;
    assign st0.headNumber      = curHead;
    assign st0.driveNumber     = curDrive;

    // ========================================================
    // input register views
    // ========================================================
    logic [7:0] viewA;
    logic [7:0] viewB;
    logic [7:0] viewC;
    logic [7:0] viewSel;
    logic [7:0] oeSel;
    logic       dskBit;
    logic       hiDens;

    // all three views are built at once and picked by the mode input, so
    // the mode never has to change while a read is in flight
    // inverted disk change
    assign dskBit = ~diskChanged;
    assign hiDens = densityBase;
    assign viewA  = {dskBit, 7'h00};
    assign viewB  = frs_pkg::ALL_ONES_MID | {dskBit, 4'h0, rate_r, hiDens};
    assign viewC  = {dskBit, 3'h0, dmaGate_r, noPrecomp_r, rate_r};
    // static mode select
    // code 3 is not a defined mode; it falls through to the mode C view
    // rather than leaving the bus undriven
    assign viewSel = (compatMode == frs_pkg::FRS_MODE_A) ? viewA :
                     (compatMode == frs_pkg::FRS_MODE_B) ? viewB : viewC;
    assign oeSel   = (compatMode == frs_pkg::FRS_MODE_A) ? 8'h80 : 8'hFF;

    // ========================================================
    // read mux and answer
    // ========================================================
    logic [7:0] rdByte;
    logic [7:0] rdOe;
    logic [7:0] ctrlByte;
    logic [7:0] resultByte;
    logic [7:0] modeByte;

    // read-back of the output control register: only the dma gate is kept,
    // the soft reset bit clears itself and reads as zero
    assign ctrlByte   = {4'h0, dmaGate_r, 3'h0};
    // result port
    // outside a result phase the port reads zero rather than stale status
    assign resultByte = resultPhase ? st0 : frs_pkg::BYTE_ZERO;
    // mode and density state, for diagnostics
    assign modeByte   = {4'h0, density_r, 1'b0, compatMode};

    // address select of the read data and of its drive enables
    assign rdByte = hitShared ? viewSel :
                    hitSt0    ? st0 :
                    hitSrc    ? st0 :
                    hitCtrl   ? ctrlByte :
                    hitResult ? resultByte :
                    hitMode   ? modeByte :
                    frs_pkg::UNMAPPED_DATA;
    // mode A leaves bits 6:0 undriven
    assign rdOe   = hitShared ? oeSel : 8'hFF;

    // one wait-free answer: ack one edge after the request, for one cycle;
    // read data stands only with ack and is zero otherwise, so a late look
    // at the bus never sees a stale byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbRsp <= '0;
        end else begin
            wbRsp.ack <= access;
            wbRsp.dat <= rdStrobe ? {24'h000000, rdByte} : 32'h00000000;
        end
    end

    // per-bit drive enables that stand with the read data; the pad ring
    // turns them into tri-state controls, this bank never floats a level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostDataOe <= 8'h00;
        end else begin
            hostDataOe <= rdStrobe ? rdOe : 8'h00;
        end
    end

    assign densityOut     = density_r;
    assign rateSelect     = rate_r;
    assign softResetPulse = softRst_r;

endmodule : frs_floppy_rate_status_regs

//--- verif/frs_drive_model.sv
// drive cable model: disk change line and head position feeding track zero
`timescale 1ns/1ps
module frs_drive_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       stepPulse,
    input  wire logic       changeReq,
    input  wire logic [7:0] startTrack,
    output logic            diskChanged,
    output logic            trackZeroIn
);
    logic [7:0] trackPos_r;
    // track zero feed
    // head moves one track per step and stops at zero, so a start at track N reports zero only after N steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            trackPos_r <= startTrack;
        else if (stepPulse && trackPos_r != 8'h00)
            trackPos_r <= trackPos_r - 8'h01;
    end
    assign trackZeroIn = (trackPos_r == 8'h00);
    assign diskChanged = changeReq;
endmodule : frs_drive_model

//--- verif/frs_floppy_rate_status_regs_bench.sv
// testbench: register views, rate, density and status byte zero against a bench model
`timescale 1ns/1ps
module frs_floppy_rate_status_regs_bench;
    localparam int RECAL = 4;
    logic                 clk = 1'b0, rst = 1'b1, diskChangeReq = 1'b0, densityPolarity = 1'b0;
    logic                 resultPhase = 1'b0, curHead = 1'b0;
    logic                 densityOut, diskChanged, trackZeroIn, softResetPulse;
    logic [1:0]           curDrive = 2'h0, rateSelect;
    logic [4:0]           pulses = 5'h00;
    logic [7:0]           hostDataOe, oe;
    logic [31:0]          rdw;
    frs_pkg::frs_wb_req_t wbReq = '0;
    frs_pkg::frs_wb_rsp_t wbRsp;
    frs_pkg::frs_mode_t   compatMode = frs_pkg::FRS_MODE_A;
    frs_pkg::frs_term_t   termCodeIn = frs_pkg::FRS_TERM_NORMAL;
    int                   n_mismatch = 0, check_count = 0, cycles = 0;
    int                   rate = 2, no_write_precomp = 0, dma = 0, np, term, se, ec;
    frs_floppy_rate_status_regs #(.RECAL_LIMIT(RECAL)) frs_floppy_rate_status_regs_i (
        .clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .hostDataOe(hostDataOe), .compatMode(compatMode),
        .diskChanged(diskChanged), .densityPolarity(densityPolarity), .trackZeroIn(trackZeroIn),
        .stepPulse(pulses[0]), .recalStart(pulses[1]), .relSeekOutward(pulses[2]), .seekComplete(pulses[3]),
        .termCodeIn(termCodeIn), .termValid(pulses[4]), .resultPhase(resultPhase), .curDrive(curDrive),
        .curHead(curHead), .densityOut(densityOut), .rateSelect(rateSelect), .softResetPulse(softResetPulse));
    frs_drive_model frs_drive_model_i (.clk(clk), .rst(rst), .stepPulse(pulses[0]), .changeReq(diskChangeReq),
        .startTrack(8'hFF), .diskChanged(diskChanged), .trackZeroIn(trackZeroIn));
    // ==========================================
    // clock and hang guard, ceiling well above the expected few hundred cycles
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // classic single cycle: hold until ack is sampled, take data at that edge, then release
    task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, d}};
        do begin
            @(posedge clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 50);
        if (wbRsp.ack !== 1'b1)
            n_mismatch++;
        rdw = wbRsp.dat;
        oe = hostDataOe;
        wbReq <= '0;
    endtask : wb
    task automatic pulse(input int k);
        @(posedge clk);
        pulses <= 5'(1 << k);
        @(posedge clk);
        pulses <= 5'h00;
    endtask : pulse
    // input view model; mode A bits 6:0 float, so only bit 7 is compared there
    function automatic logic [31:0] inView(input int m);
        logic hd;
        hd = (rate == 1 || rate == 2);
        if (m == 1)
            return {24'h0, ~diskChangeReq, 4'hF, 2'(rate), hd};
        return {24'h0, ~diskChangeReq, 3'h0, 1'(dma), 1'(no_write_precomp), 2'(rate)};
    endfunction : inView
    task automatic stRead;
        wb(1'b0, frs_pkg::ADDR_STATUS0, 8'h00);
        check(rdw, {24'h0, 2'(term), 1'(se), 1'(ec), 1'b0, curHead, curDrive});
    endtask : stRead
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h9fd58287));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(rateSelect, 32'h2);
        check(densityOut, 32'h1);
        $display("test reset done");
        for (int m = 0; m < 3; m++) begin
            compatMode <= frs_pkg::frs_mode_t'(m);
            for (int r = 0; r < 4; r++) begin
                diskChangeReq <= 1'($urandom);
                densityPolarity <= 1'($urandom);
                dma = $urandom % 2;
                np = (m == 2) ? $urandom % 2 : 0;
                wb(1'b1, frs_pkg::ADDR_OUT_CTRL, 8'(dma << 3));
                wb(1'b1, frs_pkg::ADDR_INPUT_CFG, 8'(np * 4 + r));
                rate = r;
                no_write_precomp = (m == 2) ? np : no_write_precomp;
                wb(1'b0, frs_pkg::ADDR_INPUT_CFG, 8'h00);
                check(rdw & ((m == 0) ? 32'h80 : 32'hFF), inView(m) & ((m == 0) ? 32'h80 : 32'hFF));
                check(oe, (m == 0) ? 32'h80 : 32'hFF);
                @(negedge clk);
                check(densityOut, 32'((rate == 1 || rate == 2) ^ densityPolarity));
            end
        end
        $display("test views done");
        wb(1'b1, frs_pkg::ADDR_OUT_CTRL, 8'h04);
        check(softResetPulse, 32'h1);
        check(rateSelect, 32'(rate));
        dma = 0;
        wb(1'b0, frs_pkg::ADDR_INPUT_CFG, 8'h00);
        check(rdw, inView(2));
        check(densityOut, 32'((rate == 1 || rate == 2) ^ densityPolarity));
        $display("test soft reset done");
        curDrive <= 2'($urandom);
        curHead <= 1'($urandom);
        wb(1'b1, frs_pkg::ADDR_STATUS0, 8'hFF);
        wb(1'b1, frs_pkg::ADDR_ST0_SRC, 8'h00);
        se = 0;
        ec = 0;
        for (int c = 0; c < 4; c++) begin
            termCodeIn <= frs_pkg::frs_term_t'(c);
            pulse(4);
            term = c;
            if (c == 1) begin
                pulse(3);
                se = 1;
            end
            if (c == 2) begin
                pulse(1);
                repeat (RECAL - 1) pulse(0);
                stRead();
                pulse(0);
                ec = 1;
            end
            if (c == 3) begin
                wb(1'b1, frs_pkg::ADDR_ST0_SRC, 8'h00);
                se = 0;
                pulse(2);
                ec = 1;
            end
            stRead();
        end
        resultPhase <= 1'b1;
        wb(1'b0, frs_pkg::ADDR_RESULT, 8'h00);
        check(rdw, {24'h0, 2'(term), 1'(se), 1'(ec), 1'b0, curHead, curDrive});
        resultPhase <= 1'b0;
        wb(1'b0, 12'h100, 8'h00);
        check(rdw, 32'h0);
        $display("test status done");
        test_done();
    end
endmodule : frs_floppy_rate_status_regs_bench

//--- verif/frs_regs_props.sv
// checker: port-level properties of the floppy rate/status register bank
`timescale 1ns/1ps
module frs_regs_props #(
    parameter int RECAL_LIMIT = 80
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire frs_pkg::frs_wb_req_t wbReq,
    input wire frs_pkg::frs_wb_rsp_t wbRsp,
    input wire logic [7:0]           hostDataOe,
    input wire frs_pkg::frs_mode_t   compatMode,
    input wire logic                 diskChanged,
    input wire logic                 densityPolarity,
    input wire logic                 densityOut,
    input wire logic [1:0]           rateSelect,
    input wire logic                 softResetPulse
);
    // ==========================================
    // request decode; rdIn and rdSt are sampled with the answer, taken and wrCfg with the request
    wire taken = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    wire rdIn  = wbRsp.ack && !wbReq.we && wbReq.adr == frs_pkg::ADDR_INPUT_CFG;
    wire rdSt  = wbRsp.ack && !wbReq.we && wbReq.adr == frs_pkg::ADDR_STATUS0;
    wire wrCfg = taken && wbReq.we && wbReq.sel[0] && wbReq.adr == frs_pkg::ADDR_INPUT_CFG;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    AST_ACK_ONE: assert property (taken |=> wbRsp.ack ##1 !wbRsp.ack)
        else $error("ack not a single pulse one cycle after request");
    AST_MODEA_OE: assert property (rdIn && compatMode == frs_pkg::FRS_MODE_A |-> hostDataOe == 8'h80)
        else $error("mode A read drives more than bit 7");
    AST_DISK_CHANGED: assert property (rdIn |-> wbRsp.dat[7] == !$past(diskChanged))
        else $error("bit 7 is not the inverted disk change line");
    AST_MODEB: assert property (rdIn && compatMode == frs_pkg::FRS_MODE_B |-> wbRsp.dat[6:0] ==
        {4'hF, $past(rateSelect), $past(rateSelect) == 2'h1 || $past(rateSelect) == 2'h2})
        else $error("mode B view wrong");
    AST_MODEC: assert property (rdIn && compatMode == frs_pkg::FRS_MODE_C |->
        wbRsp.dat[6:4] == 3'h0 && wbRsp.dat[1:0] == $past(rateSelect))
        else $error("mode C view wrong");
    AST_RATE_LOAD: assert property (wrCfg |=> rateSelect == $past(wbReq.dat[1:0]))
        else $error("rate not loaded from write");
    AST_DENSITY: assert property (!$past(rst) |-> densityOut ==
        (($past(rateSelect) == 2'h1 || $past(rateSelect) == 2'h2) ^ $past(densityPolarity)))
        else $error("density level does not match rate");
    AST_SOFT_KEEP: assert property (softResetPulse && !wrCfg |=> $stable(rateSelect))
        else $error("soft reset changed the rate");
    AST_ST0_BIT3: assert property (rdSt |-> wbRsp.dat[3] == 1'b0)
        else $error("status byte zero bit 3 set");
endmodule : frs_regs_props
bind frs_floppy_rate_status_regs frs_regs_props #(.RECAL_LIMIT(RECAL_LIMIT)) frs_regs_props_i (
    .clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .hostDataOe(hostDataOe), .compatMode(compatMode),
    .diskChanged(diskChanged), .densityPolarity(densityPolarity), .densityOut(densityOut),
    .rateSelect(rateSelect), .softResetPulse(softResetPulse));
